// ===== logic/ilp_regs.vh
// Constants for the interrupt and low-power sequencer.
// Assumes one clock domain at 10 MHz and a plain register port.
// Behaviour
// - Vector-2 pin entering interrupt mode while low with falling polarity latches a request.
// - Vector-2 pin leaving interrupt mode for pull-up input while low with rising polarity latches a request.
// - Accepting a request swaps to the interrupt or non-maskable flag pair.
// - Accepting a request pushes the program counter onto the stack top.
// - While servicing, further maskable lines are inhibited; non-maskable stays active except during its own routine.
// - Accepting clears the source latch and loads that source's vector address.
// - Software saves context and ends with return; return goes back to main routine.
// - Request during first 3 cycles of clearing write enters service, keeps normal flags.
// - Response from vector load to routine ready takes 6 to 11 CPU cycles.
// - One CPU cycle lasts 13 oscillator periods.
// - Option register is write-only at 0C8h, resets to 00h, written whole.
// - Option bit 6 selects vector-1 falling edge (0) or low level (1).
// - Option bit 5 selects vector-2 falling edge (0) or rising edge (1).
// - Option bit 4 gates all maskable requests; non-maskable unaffected.
// - With global enable clear, non-maskable is serviced but does not wake.
// - Fixed vector addresses; only converter source cannot wake from STOP.
// - After reset the device runs with clocks enabled.
// - WAIT halts execution, oscillator keeps running, state preserved.
// - WAIT ends on reset, peripheral or external request, then branches to its routine.
// - STOP halts execution and stops oscillator, keeping state.
// - Leaving STOP waits 2048 internal clock cycles before vectoring.
// - With watchdog active STOP acts as WAIT, unless option set and pin high.
// - Pending requests served by fixed priority, non-maskable first, then vector 1 highest of the maskable; no maskable nesting.
// - Peripheral flag interrupts only with global and own enable set.
// - WAIT or STOP is not executed while an enabled request is pending.
`ifndef ILP_REGS_VH
`define ILP_REGS_VH
`define ILP_OPT_ADDR      8'hc8
`define ILP_OPT_RESET     8'h00
`define ILP_BIT_LES       6
`define ILP_BIT_ESB       5
`define ILP_BIT_GEN       4
`define ILP_VEC_RESET     12'hffe
`define ILP_VEC_NMI       12'hffc
`define ILP_VEC_1         12'hff6
`define ILP_VEC_2         12'hff4
`define ILP_VEC_3         12'hff2
`define ILP_VEC_4         12'hff0
`define ILP_OSC_PER_CPU   13
`define ILP_RESP_MIN      6
`define ILP_RESP_MAX      11
`define ILP_STOP_DELAY    2048
`define ILP_LDI_EARLY     3
`define ILP_FLAGS_NORMAL  2'h0
`define ILP_FLAGS_IRQ     2'h1
`define ILP_FLAGS_NMI     2'h2
`endif

// ===== logic/ilp_ctrl.v
// Interrupt sequencing and WAIT/STOP control beside an 8-bit core.
// Assumes core strobes are one cycle on clk; pins are asynchronous.
//
// The address-and-strobe port was left to the implementer.
`include "ilp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ilp_ctrl #(
    parameter NPORT      = 8,
    parameter STOP_DELAY = `ILP_STOP_DELAY
) (
    // Clock and reset
    input  wire             clk,
    input  wire             resetn,
    // Register port
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    // Interrupt pins (asynchronous)
    input  wire             nmi_pin_n,
    input  wire             vec1_pin,
    input  wire [NPORT-1:0] vec2_pins,
    // Vector-2 port configuration from the port block
    input  wire [NPORT-1:0] port_direction_bits,
    input  wire [NPORT-1:0] port_option_bits,
    input  wire [NPORT-1:0] port_data_bits,
    // Peripheral flags and enables
    input  wire             timer_zero_flag,
    input  wire             timer_int_en,
    input  wire             conv_eoc_flag,
    input  wire             conv_int_en,
    // Watchdog and option
    input  wire             watchdog_active,
    input  wire             stop_with_watchdog_opt,
    // Core side
    input  wire             instr_boundary,
    input  wire             wait_exec,
    input  wire             stop_exec,
    input  wire             return_from_interrupt,
    input  wire             opt_clear_ldi,
    input  wire [1:0]       ldi_cycle,
    input  wire [11:0]      core_pc,
    input  wire [11:0]      stack_pc,
    input  wire [3:0]       resp_extra,
    output reg              irq_take,
    output reg  [11:0]      pc_load,
    output reg              stack_push,
    output reg  [11:0]      stack_push_pc,
    output reg              stack_pop,
    output reg  [1:0]       flag_pair_sel,
    output reg              isr_ready,
    output reg              cpu_clk_en,
    output reg              cpu_cycle_en,
    output reg              osc_run,
    output reg              periph_clk_en,
    output reg              watchdog_freeze
);
    // ****************************************
    // Functions and states
    // ****************************************
    localparam [1:0] S_RUN = 2'h0;
    localparam [1:0] S_WAIT = 2'h1;
    localparam [1:0] S_STOP = 2'h2;
    localparam [1:0] S_RESTART = 2'h3;
    localparam [11:0] STOP_CNT = STOP_DELAY;
    localparam [3:0]  RESP_MIN = `ILP_RESP_MIN;
    localparam [3:0]  RESP_MAX = `ILP_RESP_MAX;
    localparam [3:0]  RESP_SPAN = RESP_MAX - RESP_MIN;

    function [NPORT-1:0] int_cfg;
        input [NPORT-1:0] ddr;
        input [NPORT-1:0] opt;
        input [NPORT-1:0] dat;
        begin
            int_cfg = ~ddr & opt & ~dat;
        end
    endfunction

    function [NPORT-1:0] pullup_cfg;
        input [NPORT-1:0] ddr;
        input [NPORT-1:0] opt;
        input [NPORT-1:0] dat;
        begin
            pullup_cfg = ~ddr & ~opt & ~dat;
        end
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [2:0]       nmi_s_reg;
    reg [2:0]       v1_s_reg;
    reg [NPORT-1:0] v2_s1_reg;
    reg [NPORT-1:0] v2_s2_reg;
    reg [NPORT-1:0] v2_s3_reg;
    reg             nmi_lvl_reg;
    reg             v1_lvl_reg;
    reg [NPORT-1:0] v2_lvl_reg;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nmi_s_reg   <= 3'h7;
            v1_s_reg    <= 3'h7;
            v2_s1_reg   <= {NPORT{1'b1}};
            v2_s2_reg   <= {NPORT{1'b1}};
            v2_s3_reg   <= {NPORT{1'b1}};
            nmi_lvl_reg <= 1'b1;
            v1_lvl_reg  <= 1'b1;
            v2_lvl_reg  <= {NPORT{1'b1}};
        end else begin
            nmi_s_reg <= {nmi_s_reg[1:0], nmi_pin_n};
            v1_s_reg  <= {v1_s_reg[1:0], vec1_pin};
            v2_s1_reg <= vec2_pins;
            v2_s2_reg <= v2_s1_reg;
            v2_s3_reg <= v2_s2_reg;
            if (nmi_s_reg[1] == nmi_s_reg[2])
                nmi_lvl_reg <= nmi_s_reg[2];
            if (v1_s_reg[1] == v1_s_reg[2])
                v1_lvl_reg <= v1_s_reg[2];
            v2_lvl_reg <= (v2_s2_reg & v2_s3_reg) | (v2_lvl_reg & (v2_s2_reg | v2_s3_reg));
        end
    end

    // ****************************************
    // Option register and request latches
    // ****************************************
    reg  [7:0]       opt_reg;
    reg              nmi_prev_reg;
    reg              v1_prev_reg;
    reg              v2_prev_reg;
    reg  [NPORT-1:0] cfg_prev_reg;
    reg              nmi_latch_reg;
    reg              v1_latch_reg;
    reg              v2_latch_reg;
    wire             gen    = opt_reg[`ILP_BIT_GEN];
    wire             level_edge_select    = opt_reg[`ILP_BIT_LES];
    wire             edge_polarity_select    = opt_reg[`ILP_BIT_ESB];
    wire [NPORT-1:0] cfg_int = int_cfg(port_direction_bits, port_option_bits, port_data_bits);
    wire [NPORT-1:0] cfg_pu = pullup_cfg(port_direction_bits, port_option_bits, port_data_bits);
    // Shared line: one stuck pin masks the others, as on the real wiring
    wire             v2_line = edge_polarity_select ? |(v2_lvl_reg & cfg_int) : ~|(~v2_lvl_reg & cfg_int);
    wire             v2_edge = edge_polarity_select ? (v2_line & ~v2_prev_reg) : (~v2_line & v2_prev_reg);
    wire [NPORT-1:0] low_pins = ~v2_lvl_reg;
    wire             v2_spur_in = |(low_pins & cfg_int & ~cfg_prev_reg) & ~edge_polarity_select;
    wire             v2_spur_out = |(low_pins & cfg_pu & cfg_prev_reg) & edge_polarity_select;
    wire             nmi_edge = nmi_prev_reg & ~nmi_lvl_reg;
    wire             v1_edge = v1_prev_reg & ~v1_lvl_reg;
    wire             opt_wr = reg_wr && (reg_addr == `ILP_OPT_ADDR);
    wire [3:0]       take_oh;
    wire             take_nmi;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opt_reg       <= `ILP_OPT_RESET;
            nmi_prev_reg  <= 1'b1;
            v1_prev_reg   <= 1'b1;
            v2_prev_reg   <= 1'b1;
            cfg_prev_reg  <= {NPORT{1'b0}};
            nmi_latch_reg <= 1'b0;
            v1_latch_reg  <= 1'b0;
            v2_latch_reg  <= 1'b0;
        end else begin
            if (opt_wr)
                opt_reg <= reg_wdata;
            nmi_prev_reg <= nmi_lvl_reg;
            v1_prev_reg  <= v1_lvl_reg;
            v2_prev_reg  <= v2_line;
            cfg_prev_reg <= cfg_int;
            // Set wins over the clear done at acceptance
            if (nmi_edge)
                nmi_latch_reg <= 1'b1;
            else if (take_nmi)
                nmi_latch_reg <= 1'b0;
            if (v1_edge && !level_edge_select)
                v1_latch_reg <= 1'b1;
            else if (take_oh[0] || level_edge_select)
                v1_latch_reg <= 1'b0;
            if (v2_edge || v2_spur_in || v2_spur_out)
                v2_latch_reg <= 1'b1;
            else if (take_oh[1])
                v2_latch_reg <= 1'b0;
        end
    end

    // ****************************************
    // Priority and pending requests
    // ****************************************
    wire v1_req = level_edge_select ? ~v1_lvl_reg : v1_latch_reg;
    wire tmr_req = timer_zero_flag & timer_int_en;
    wire cnv_req = conv_eoc_flag & conv_int_en;
    wire [3:0] mreq = {cnv_req, tmr_req, v2_latch_reg, v1_req};
    wire [3:0] mreq_en = gen ? mreq : 4'h0;
    wire any_m = |mreq_en;
    // Lowest index is vector 1, highest priority
    wire [3:0] prio_oh = mreq_en & ~(mreq_en - 4'h1);
    wire [3:0] stop_wake = {1'b0, mreq_en[2:0]};
    // Non-maskable wakes only with global enable set
    wire nmi_wake = nmi_latch_reg & gen;

    // ****************************************
    // Sequencer
    // ****************************************
    reg [1:0]  state_reg;
    reg [1:0]  mode_reg;
    reg [1:0]  saved_mode_reg;
    reg [1:0]  nmi_saved_reg;
    reg [1:0]  saved_flags_reg;
    reg [1:0]  nmi_saved_flags_reg;
    reg [11:0] cnt_reg;
    reg [3:0]  osc_div_reg;
    reg [3:0]  resp_reg;
    reg        resp_busy_reg;
    reg        keep_normal_reg;
    wire mask_ok = (mode_reg == `ILP_FLAGS_NORMAL);
    wire nmi_ok = (mode_reg != `ILP_FLAGS_NMI);
    wire can_take = (state_reg == S_RUN) && instr_boundary && !resp_busy_reg;
    assign take_nmi = can_take && nmi_latch_reg && nmi_ok;
    assign take_oh = (can_take && !take_nmi && mask_ok) ? prio_oh : 4'h0;
    wire take_any = take_nmi || (|take_oh);
    wire pend_en = any_m || nmi_latch_reg;
    wire stop_real = !watchdog_active || (stop_with_watchdog_opt && nmi_lvl_reg);
    wire early_ldi = opt_clear_ldi && (ldi_cycle < `ILP_LDI_EARLY);
    reg [11:0] vec_sel;

    always @* begin
        vec_sel = `ILP_VEC_4;
        if (take_nmi)
            vec_sel = `ILP_VEC_NMI;
        else if (take_oh[0])
            vec_sel = `ILP_VEC_1;
        else if (take_oh[1])
            vec_sel = `ILP_VEC_2;
        else if (take_oh[2])
            vec_sel = `ILP_VEC_3;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg           <= S_RUN;
            mode_reg            <= `ILP_FLAGS_NORMAL;
            saved_mode_reg      <= `ILP_FLAGS_NORMAL;
            nmi_saved_reg       <= `ILP_FLAGS_NORMAL;
            saved_flags_reg     <= `ILP_FLAGS_NORMAL;
            nmi_saved_flags_reg <= `ILP_FLAGS_NORMAL;
            cnt_reg             <= 12'h000;
            osc_div_reg         <= 4'h0;
            resp_reg            <= 4'h0;
            resp_busy_reg       <= 1'b0;
            keep_normal_reg     <= 1'b0;
            irq_take            <= 1'b0;
            pc_load             <= `ILP_VEC_RESET;
            stack_push          <= 1'b0;
            stack_push_pc       <= 12'h000;
            stack_pop           <= 1'b0;
            flag_pair_sel       <= `ILP_FLAGS_NORMAL;
            isr_ready           <= 1'b0;
            cpu_clk_en          <= 1'b1;
            cpu_cycle_en        <= 1'b0;
            osc_run             <= 1'b1;
            periph_clk_en       <= 1'b1;
            watchdog_freeze     <= 1'b0;
            reg_rdata           <= 8'h00;
        end else begin
            irq_take   <= 1'b0;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
            isr_ready  <= 1'b0;
            // Write-only register: reads return zero, no state exposed
            reg_rdata  <= 8'h00;
            // Oscillator-period divider gives one CPU cycle enable
            cpu_cycle_en <= 1'b0;
            if (osc_run) begin
                if (osc_div_reg == `ILP_OSC_PER_CPU - 1) begin
                    osc_div_reg  <= 4'h0;
                    cpu_cycle_en <= 1'b1;
                end else begin
                    osc_div_reg <= osc_div_reg + 4'h1;
                end
            end
            if (resp_busy_reg && cpu_cycle_en) begin
                if (resp_reg == 4'h1) begin
                    resp_busy_reg <= 1'b0;
                    isr_ready     <= 1'b1;
                end
                resp_reg <= resp_reg - 4'h1;
            end
            case (state_reg)
            S_RUN: begin
                if (take_any) begin
                    irq_take      <= 1'b1;
                    pc_load       <= vec_sel;
                    stack_push    <= 1'b1;
                    stack_push_pc <= core_pc;
                    resp_busy_reg <= 1'b1;
                    // Figure clamps to the documented window
                    resp_reg <= (resp_extra > RESP_SPAN) ? RESP_MAX :
                                RESP_MIN + resp_extra;
                    if (take_nmi) begin
                        nmi_saved_reg       <= mode_reg;
                        nmi_saved_flags_reg <= flag_pair_sel;
                        mode_reg            <= `ILP_FLAGS_NMI;
                        flag_pair_sel       <= `ILP_FLAGS_NMI;
                    end else begin
                        saved_mode_reg  <= mode_reg;
                        saved_flags_reg <= flag_pair_sel;
                        mode_reg        <= `ILP_FLAGS_IRQ;
                        keep_normal_reg <= early_ldi;
                        if (!early_ldi)
                            flag_pair_sel <= `ILP_FLAGS_IRQ;
                        else
                            flag_pair_sel <= `ILP_FLAGS_NORMAL;
                    end
                end else if (return_from_interrupt && mode_reg != `ILP_FLAGS_NORMAL) begin
                    stack_pop <= 1'b1;
                    if (mode_reg == `ILP_FLAGS_NMI) begin
                        mode_reg      <= nmi_saved_reg;
                        flag_pair_sel <= nmi_saved_flags_reg;
                    end else begin
                        mode_reg        <= `ILP_FLAGS_NORMAL;
                        flag_pair_sel   <= `ILP_FLAGS_NORMAL;
                        keep_normal_reg <= 1'b0;
                    end
                    pc_load <= stack_pc;
                end else if ((wait_exec || stop_exec) && !pend_en) begin
                    cpu_clk_en <= 1'b0;
                    if (stop_exec && stop_real) begin
                        state_reg       <= S_STOP;
                        osc_run         <= 1'b0;
                        periph_clk_en   <= 1'b0;
                        watchdog_freeze <= watchdog_active;
                    end else begin
                        state_reg <= S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                if (any_m || nmi_wake) begin
                    state_reg  <= S_RUN;
                    cpu_clk_en <= 1'b1;
                end
            end
            S_STOP: begin
                if ((|stop_wake) || nmi_wake) begin
                    state_reg <= S_RESTART;
                    osc_run   <= 1'b1;
                    cnt_reg   <= STOP_CNT - 12'h001;
                end
            end
            S_RESTART: begin
                if (cnt_reg == 12'h000) begin
                    state_reg       <= S_RUN;
                    cpu_clk_en      <= 1'b1;
                    periph_clk_en   <= 1'b1;
                    watchdog_freeze <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 12'h001;
                end
            end
            default: state_reg <= S_RUN;
            endcase
        end
    end
endmodule // ilp_ctrl
`default_nettype wire

// ===== testbench/ilp_monitor.sv
// Port checker for the interrupt and low-power sequencer.
// Assumes it is bound onto ilp_ctrl and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module ilp_monitor #(
    parameter int STOP_DELAY = 2048
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Sequencer outputs
    input wire logic [7:0]  reg_rdata,
    input wire logic        irq_take,
    input wire logic        stack_push,
    input wire logic        stack_pop,
    input wire logic [11:0] pc_load,
    input wire logic [1:0]  flag_pair_sel,
    input wire logic        isr_ready,
    input wire logic        cpu_cycle_en,
    input wire logic        cpu_clk_en,
    input wire logic        osc_run,
    input wire logic        periph_clk_en,
    // Core side inputs
    input wire logic [11:0] stack_pc,
    input wire logic        stop_exec,
    input wire logic        opt_clear_ldi
);
    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_opt_readback: assert property (reg_rdata == 8'h00)
        else $error("option register read back non-zero");
    chk_take_vector: assert property (irq_take |-> stack_push && pc_load inside {12'hffc, 12'hff6, 12'hff4, 12'hff2, 12'hff0})
        else $error("accept without push or with bad vector");
    chk_take_flags: assert property (irq_take && !$past(opt_clear_ldi) |-> flag_pair_sel != 2'h0)
        else $error("accept kept normal flag pair");
    chk_response_time: assert property (irq_take |=> !isr_ready [*8] ##[50:142] isr_ready)
        else $error("routine ready outside 6 to 11 cpu cycles");
    chk_cpu_cycle_gap: assert property (cpu_cycle_en |=> !cpu_cycle_en [*8])
        else $error("cpu cycle strobes too close");
    chk_restart_delay: assert property ($rose(osc_run) |-> !cpu_clk_en [*8])
        else $error("cpu clock back before oscillator settled");
    chk_wait_osc_on: assert property ($fell(cpu_clk_en) && !$past(stop_exec) |-> osc_run && periph_clk_en)
        else $error("idle without stop lost the oscillator");
    chk_return_pc: assert property (stack_pop |-> pc_load == $past(stack_pc))
        else $error("return did not reload stacked address");
endmodule // ilp_monitor
`default_nettype wire

// ===== testbench/ilp_core_model.sv
// Core-side partner: offers every boundary and keeps the stack top.
// Assumes it shares clk and resetn with ilp_ctrl.
`timescale 1ns/1ps
`default_nettype none
module ilp_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // From the sequencer
    input  wire logic        stack_push,
    input  wire logic [11:0] stack_push_pc,
    input  wire logic        cpu_cycle_en,
    // To the sequencer
    output logic             instr_boundary,
    output logic [11:0]      core_pc,
    output logic [11:0]      stack_pc,
    output logic [3:0]       resp_extra
);
    // ************************************************
    // Core behaviour
    // ************************************************
    // One level only: the bench never nests routines
    assign instr_boundary = 1'b1;
    assign resp_extra     = 4'h2;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_pc  <= 12'h000;
            stack_pc <= 12'h000;
        end else begin
            if (cpu_cycle_en) core_pc <= core_pc + 12'h001;
            if (stack_push) stack_pc <= stack_push_pc;
        end
    end
endmodule // ilp_core_model
`default_nettype wire

// ===== testbench/tb_interrupt_and_low_power_control.sv
// Self-checking bench for the interrupt and low-power sequencer.
// Assumes ilp_ctrl, ilp_core_model and ilp_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_and_low_power_control;
    localparam int SD = 16;
    logic        clk, resetn, reg_wr, reg_rd, nmi_pin_n, vec1_pin, stop_exec, wait_exec;
    logic        timer_zero_flag, timer_int_en, conv_eoc_flag, conv_int_en, return_from_interrupt;
    logic [7:0]  reg_addr, reg_wdata, vec2_pins, port_option_bits, port_data_bits;
    wire  [7:0]  reg_rdata;
    wire  [7:0]  port_direction_bits = 8'h00;
    wire  [1:0]  ldi_cycle = 2'h0;
    logic        watchdog_active, opt_clear_ldi;
    wire         stop_with_watchdog_opt = 1'b0;
    wire         instr_boundary, irq_take, stack_push, stack_pop, isr_ready, watchdog_freeze;
    wire         cpu_clk_en, cpu_cycle_en, osc_run, periph_clk_en;
    wire  [11:0] core_pc, stack_pc, pc_load, stack_push_pc;
    wire  [3:0]  resp_extra;
    wire  [1:0]  flag_pair_sel;
    int          n_mismatch, checks_done;
    ilp_ctrl #(.NPORT(8), .STOP_DELAY(SD)) dut (.*);
    ilp_core_model core (.*);
    // ************************************************
    // Helpers
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task to(input int i, input int n);
        if (i >= n) begin
            n_mismatch++;
            $display("[FAIL] wait expected done seen timeout");
            wrap_up;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp("read data", 0, reg_rdata);
    endtask
    task quiet(input int n);
        repeat (n) begin
            @(posedge clk) #1;
            cmp("idle", 0, irq_take);
        end
    endtask
    task take(input logic [11:0] v, input logic [1:0] f);
        int i;
        i = 0;
        do begin
            @(posedge clk) #1;
            i++;
        end while (irq_take !== 1'b1 && i < 300);
        to(i, 300);
        cmp("vector", v, pc_load);
        cmp("flag pair", f, flag_pair_sel);
        cmp("stack push", 1, stack_push);
    endtask
    task ret;
        int i;
        for (i = 0; i < 200 && isr_ready !== 1'b1; i++) begin
            @(posedge clk) #1;
            cmp("nested take", 0, irq_take);
        end
        to(i, 200);
        cmp("response time", 1, i >= 60);
        return_from_interrupt <= 1'b1;
        @(posedge clk);
        return_from_interrupt <= 1'b0;
        #1 cmp("stack pop", 1, stack_pop);
        cmp("return pc", stack_pc, pc_load);
        cmp("flags back", 0, flag_pair_sel);
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task t_gate;
        wr(8'hc8, 8'h00);
        timer_zero_flag <= 1'b1;
        timer_int_en <= 1'b1;
        quiet(40);
        timer_int_en <= 1'b0;
        wr(8'hc8, 8'h10);
        quiet(40);
        timer_int_en <= 1'b1;
        take(12'hff2, 2'h1);
        timer_zero_flag <= 1'b0;
        ret;
    endtask
    task t_prio;
        wr(8'hc8, 8'h00);
        vec1_pin <= 1'b0;
        conv_eoc_flag <= 1'b1;
        conv_int_en <= 1'b1;
        timer_zero_flag <= 1'b1;
        quiet(8);
        wr(8'hc8, 8'h10);
        take(12'hff6, 2'h1);
        vec1_pin <= 1'b1;
        ret;
        take(12'hff2, 2'h1);
        timer_zero_flag <= 1'b0;
        ret;
        take(12'hff0, 2'h1);
        conv_eoc_flag <= 1'b0;
        ret;
        quiet(40);
    endtask
    task t_spur;
        vec2_pins <= 8'hfe;
        quiet(8);
        port_option_bits <= 8'h01;
        take(12'hff4, 2'h1);
        vec2_pins <= 8'hff;
        ret;
        port_option_bits <= 8'h00;
    endtask
    task t_misc;
        opt_clear_ldi <= 1'b1;
        timer_zero_flag <= 1'b1;
        take(12'hff2, 2'h0);
        {opt_clear_ldi, timer_zero_flag} <= 2'h0;
        ret;
        watchdog_active <= 1'b1;
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        repeat (3) @(posedge clk);
        #1 cmp("watchdog stop", 1, osc_run && !cpu_clk_en);
        timer_zero_flag <= 1'b1;
        take(12'hff2, 2'h1);
        {watchdog_active, timer_zero_flag} <= 2'h0;
        ret;
        wr(8'hc8, 8'h50);
        vec1_pin <= 1'b0;
        take(12'hff6, 2'h1);
        vec1_pin <= 1'b1;
        ret;
        wr(8'hc8, 8'h10);
    endtask
    task t_stop;
        int i;
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        repeat (3) @(posedge clk);
        #1 cmp("stop osc", 0, osc_run);
        cmp("stop cpu", 0, cpu_clk_en);
        vec1_pin <= 1'b0;
        for (i = 0; i < 60 && osc_run !== 1'b1; i++) @(posedge clk) #1;
        to(i, 60);
        for (i = 0; i < 3 * SD && cpu_clk_en !== 1'b1; i++) @(posedge clk) #1;
        cmp("restart delay", 1, i >= SD - 2 && i <= SD + 1);
        take(12'hff6, 2'h1);
        vec1_pin <= 1'b1;
        ret;
    endtask
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        {reg_wr, reg_rd, stop_exec, wait_exec, return_from_interrupt, resetn} = '0;
        {opt_clear_ldi, watchdog_active} = '0;
        {timer_zero_flag, timer_int_en, conv_eoc_flag, conv_int_en} = '0;
        {nmi_pin_n, vec1_pin, vec2_pins} = 10'h3ff;
        {reg_addr, reg_wdata, port_option_bits, port_data_bits} = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk) #1 cmp("run after reset", 1, cpu_clk_en && osc_run);
        wr(8'hc8, 8'h10);
        rd(8'hc8);
        rd(8'h3a);
        t_gate;
        t_prio;
        nmi_pin_n <= 1'b0;
        take(12'hffc, 2'h2);
        nmi_pin_n <= 1'b1;
        ret;
        t_spur;
        wait_exec <= 1'b1;
        @(posedge clk);
        wait_exec <= 1'b0;
        repeat (3) @(posedge clk);
        #1 cmp("idle keeps osc", 1, osc_run && !cpu_clk_en);
        timer_zero_flag <= 1'b1;
        take(12'hff2, 2'h1);
        timer_zero_flag <= 1'b0;
        ret;
        t_misc;
        t_stop;
        wrap_up;
    end
endmodule // tb_interrupt_and_low_power_control
bind ilp_ctrl ilp_monitor #(.STOP_DELAY(STOP_DELAY)) u_mon (.*);
`default_nettype wire
